// ===== hw/cpu_exception_entry_priority.sv
// exception masking, abort handling, priority and entry of the core
// Function
// - fast interrupt requests ignored while fast mask bit is 1; the fast entry chained after abort entry is still taken
// - user mode writes cannot change the fast mask bit
// - normal interrupts ignored while normal mask is 1; changed only privileged
// - normal interrupts stay masked during fast interrupt handling
// - aborts seen in memory cycle, split into prefetch and data aborts
// - prefetch abort tags instruction; taken only if it reaches head
// - aborted single load or store still performs base writeback
// - aborted atomic swap changes no register and no memory
// - aborted multi transfer completes, including base writeback
// - after an abort every register load from memory is suppressed
// - fixed vectors four bytes apart from address zero
// - software trap enters supervisor mode at its vector
// - unimplemented opcode enters undefined mode
// - status-restoring return reloads status from the saved copy
// - priority: reset, data abort, fast, normal, prefetch, undefined/trap
// - undefined and software trap share the lowest level; here undefined wins if both are flagged
// - data abort with enabled fast interrupt: abort entry then fast vector
// - reset copies pc and status into supervisor link and saved status
// - reset sets supervisor mode, both masks, clears compact state
// - first fetch after reset from address zero in 32-bit state
// - entry saves return, status, sets mode, masks, vector, leaves compact
// - return address is pc plus 2, 4 or 8 by type and state
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
module cpu_exception_entry_priority
    import exc_entry_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_fiq_req,
    input wire logic i_irq_req,
    input wire logic i_fetch_done,
    input wire logic i_bus_abort,
    input wire logic i_pipe_flush,
    input wire logic i_data_access,
    input wire logic [1:0] i_xfer_kind,
    input wire logic i_boundary,
    input wire logic i_head_undefined,
    input wire logic i_head_trap,
    input wire logic [31:0] i_pc,
    input wire logic i_status_write,
    input wire logic [31:0] i_status_wdata,
    input wire logic i_status_restore,
    output logic [31:0] o_current_status_word,
    output logic [31:0] o_saved_status_word,
    output logic o_pc_load,
    output logic [31:0] o_pc_target,
    output logic o_link_write,
    output logic [2:0] o_link_bank,
    output logic [31:0] o_link_data,
    output logic o_reg_load_suppress,
    output logic o_swap_suppress
);

    typedef struct packed {
        logic [2:0] fiq_sync;
        logic [2:0] irq_sync;
        logic fiq_level;
        logic irq_level;
        logic [1:0] pabt_tag;
        logic dabt_pending;
        logic abort_seen;
        logic abort_swap;
        logic chain_fiq;
        logic reset_pending;
        logic [31:0] status;
        logic [NUM_BANKS-1:0][31:0] saved;
        logic [31:0] saved_out;
        logic pc_load;
        logic [31:0] pc_target;
        logic link_write;
        logic [2:0] link_bank;
        logic [31:0] link_data;
        exc_type last_taken;
    } state_type;

    localparam state_type STATE_RESET = '{
        status: STATUS_RESET,
        reset_pending: 1'b1,
        last_taken: EXC_NONE,
        default: '0
    };

    state_type r;
    state_type next_r;

    function automatic logic [31:0] vector_of(input exc_type e);
        case (e)
            EXC_UND: vector_of = VEC_UND;
            EXC_TRAP: vector_of = VEC_TRAP;
            EXC_PABT: vector_of = VEC_PABT;
            EXC_DABT: vector_of = VEC_DABT;
            EXC_IRQ: vector_of = VEC_IRQ;
            EXC_FIQ: vector_of = VEC_FIQ;
            default: vector_of = VEC_RESET;
        endcase
    endfunction : vector_of

    function automatic logic [4:0] mode_of(input exc_type e);
        case (e)
            EXC_UND: mode_of = MODE_UND;
            EXC_PABT, EXC_DABT: mode_of = MODE_ABT;
            EXC_IRQ: mode_of = MODE_IRQ;
            EXC_FIQ: mode_of = MODE_FIQ;
            default: mode_of = MODE_SVC;
        endcase
    endfunction : mode_of

    function automatic logic [2:0] bank_of(input logic [4:0] m);
        case (m)
            MODE_SVC: bank_of = BANK_SVC;
            MODE_ABT: bank_of = BANK_ABT;
            MODE_UND: bank_of = BANK_UND;
            MODE_IRQ: bank_of = BANK_IRQ;
            MODE_FIQ: bank_of = BANK_FIQ;
            default: bank_of = BANK_NONE;
        endcase
    endfunction : bank_of

    // return offset by type and compact state
    function automatic logic [31:0] ret_off(input exc_type e, input logic compact);
        case (e)
            EXC_UND, EXC_TRAP: ret_off = compact ? RET_OFF_2 : RET_OFF_4;
            EXC_DABT: ret_off = RET_OFF_8;
            default: ret_off = RET_OFF_4;
        endcase
    endfunction : ret_off

    exc_type take;
    logic [2:0] bank;
    logic [2:0] cur_bank;
    logic [31:0] base_pc;

    always_comb begin
        next_r = r;
        next_r.pc_load = 1'b0;
        next_r.link_write = 1'b0;
        next_r.last_taken = EXC_NONE;
        take = EXC_NONE;
        bank = BANK_NONE;
        base_pc = i_pc;
        cur_bank = bank_of(r.status[MODE_LSB +: 5]);

        // three-stage pin sampling, level moves when stages two and three agree
        next_r.fiq_sync = {r.fiq_sync[1:0], i_fiq_req};
        next_r.irq_sync = {r.irq_sync[1:0], i_irq_req};
        if (r.fiq_sync[1] == r.fiq_sync[2]) begin
            next_r.fiq_level = r.fiq_sync[2];
        end
        if (r.irq_sync[1] == r.irq_sync[2]) begin
            next_r.irq_level = r.irq_sync[2];
        end

        // abort tag travels with the fetched instruction
        if (i_pipe_flush) begin
            next_r.pabt_tag = 2'h0;
        end else if (i_fetch_done) begin
            next_r.pabt_tag = {r.pabt_tag[0], i_bus_abort};
        end

        if (i_data_access && i_bus_abort) begin
            next_r.dabt_pending = 1'b1;
            next_r.abort_seen = 1'b1;
            // single and multi keep base writeback, swap loses everything
            next_r.abort_swap = (i_xfer_kind == XFER_SWAP);
        end

        if (i_status_write) begin
            next_r.status = i_status_wdata;
            if (r.status[MODE_LSB +: 5] == MODE_USER) begin
                next_r.status[BIT_F] = r.status[BIT_F];
                next_r.status[BIT_I] = r.status[BIT_I];
                next_r.status[MODE_LSB +: 5] = MODE_USER;
            end
        end else if (i_status_restore && cur_bank != BANK_NONE) begin
            next_r.status = r.saved[cur_bank];
        end

        if (r.reset_pending) begin
            take = EXC_RESET;
        end else if (r.chain_fiq) begin
            take = EXC_FIQ;
            base_pc = VEC_DABT;
        end else if (i_boundary) begin
            if (r.dabt_pending) begin
                take = EXC_DABT;
            end else if (r.fiq_level && !r.status[BIT_F]) begin
                take = EXC_FIQ;
            end else if (r.irq_level && !r.status[BIT_I]
                         && r.status[MODE_LSB +: 5] != MODE_FIQ) begin
                take = EXC_IRQ;
            end else if (r.pabt_tag[1]) begin
                take = EXC_PABT;
            end else if (i_head_undefined) begin
                take = EXC_UND;
            end else if (i_head_trap) begin
                take = EXC_TRAP;
            end
        end

        if (take != EXC_NONE) begin
            bank = bank_of(mode_of(take));
            next_r.saved[bank] = r.status;
            next_r.link_write = 1'b1;
            next_r.link_bank = bank;
            if (take == EXC_RESET) begin
                next_r.link_data = i_pc;
            end else begin
                next_r.link_data = base_pc + ret_off(take, r.status[BIT_T]);
            end
            next_r.status[MODE_LSB +: 5] = mode_of(take);
            next_r.status[BIT_I] = 1'b1;
            next_r.status[BIT_F] = 1'b1;
            next_r.status[BIT_T] = 1'b0;
            next_r.pc_load = 1'b1;
            next_r.pc_target = vector_of(take);
            next_r.last_taken = take;
            next_r.pabt_tag = 2'h0;
            next_r.reset_pending = 1'b0;
            next_r.chain_fiq = 1'b0;
            if (take == EXC_DABT) begin
                // an abort arriving in the entry cycle stays pending
                next_r.dabt_pending = i_data_access && i_bus_abort;
                next_r.abort_seen = i_data_access && i_bus_abort;
                next_r.abort_swap = i_data_access && i_bus_abort && (i_xfer_kind == XFER_SWAP);
                // enabled fast request rides straight after abort entry
                next_r.chain_fiq = r.fiq_level && !r.status[BIT_F];
            end
        end

        if (bank_of(next_r.status[MODE_LSB +: 5]) == BANK_NONE) begin
            next_r.saved_out = 32'h00000000;
        end else begin
            next_r.saved_out = next_r.saved[bank_of(next_r.status[MODE_LSB +: 5])];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            r <= STATE_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign o_current_status_word = r.status;
    assign o_saved_status_word = r.saved_out;
    assign o_pc_load = r.pc_load;
    assign o_pc_target = r.pc_target;
    assign o_link_write = r.link_write;
    assign o_link_bank = r.link_bank;
    assign o_link_data = r.link_data;
    assign o_reg_load_suppress = r.abort_seen;
    assign o_swap_suppress = r.abort_swap;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    sequence s_dabt_entry;
        r.last_taken == EXC_DABT && r.chain_fiq;
    endsequence

    sequence s_fiq_entry;
        r.last_taken == EXC_FIQ && r.pc_target == VEC_FIQ
            && r.link_data == VEC_DABT + RET_OFF_4;
    endsequence

    property p_fiq_masked;
        (!r.reset_pending && !r.chain_fiq && r.status[BIT_F]) |=> r.last_taken != EXC_FIQ;
    endproperty
    a_fiq_masked: assert property (p_fiq_masked)
        else $error("fast interrupt taken while masked");

    property p_user_masks;
        (i_status_write && !i_boundary && !r.reset_pending && !r.chain_fiq
            && r.status[MODE_LSB +: 5] == MODE_USER)
            |=> $stable(r.status[BIT_I:BIT_F]);
    endproperty
    a_user_masks: assert property (p_user_masks)
        else $error("user write changed a mask bit");

    property p_irq_in_fiq;
        (r.status[MODE_LSB +: 5] == MODE_FIQ) |=> r.last_taken != EXC_IRQ;
    endproperty
    a_irq_in_fiq: assert property (p_irq_in_fiq)
        else $error("normal interrupt taken in fast mode");

    property p_flush_clears_tag;
        (i_pipe_flush) |=> r.pabt_tag == 2'h0;
    endproperty
    a_flush_clears_tag: assert property (p_flush_clears_tag)
        else $error("prefetch abort tag survived a flush");

    property p_load_block;
        (i_data_access && i_bus_abort) |=> o_reg_load_suppress && (o_swap_suppress ==
            ($past(i_xfer_kind) == XFER_SWAP));
    endproperty
    a_load_block: assert property (p_load_block)
        else $error("register load not suppressed after abort");

    property p_vector;
        o_pc_load |-> o_pc_target == vector_of(r.last_taken);
    endproperty
    a_vector: assert property (p_vector)
        else $error("wrong vector address");

    property p_vector_step;
        o_pc_load |-> o_pc_target[31:5] == 27'h0 && o_pc_target[1:0] == 2'h0
            && o_pc_target != VEC_RSVD;
    endproperty
    a_vector_step: assert property (p_vector_step)
        else $error("vector outside the table");

    property p_dabt_first;
        (i_boundary && r.dabt_pending && !r.reset_pending && !r.chain_fiq)
            |=> r.last_taken == EXC_DABT && r.status[MODE_LSB +: 5] == MODE_ABT;
    endproperty
    a_dabt_first: assert property (p_dabt_first)
        else $error("data abort lost priority");

    property p_chain;
        s_dabt_entry |=> s_fiq_entry;
    endproperty
    a_chain: assert property (p_chain)
        else $error("fast entry did not follow abort entry");

    property p_reset_state;
        $fell(i_rst) |-> r.status == STATUS_RESET ##1 (r.pc_load && r.pc_target == RESET_PC
            && r.status[MODE_LSB +: 5] == MODE_SVC && !r.status[BIT_T]);
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("reset entry state wrong");

    property p_trap_return;
        (i_boundary && i_head_trap && !i_head_undefined && !r.dabt_pending
            && !r.pabt_tag[1] && !r.reset_pending && !r.chain_fiq
            && !(r.fiq_level && !r.status[BIT_F])
            && !(r.irq_level && !r.status[BIT_I]))
            |=> r.link_data == $past(i_pc) + ($past(r.status[BIT_T]) ? RET_OFF_2 : RET_OFF_4)
            && r.status[MODE_LSB +: 5] == MODE_SVC;
    endproperty
    a_trap_return: assert property (p_trap_return)
        else $error("software trap return address wrong");

endmodule : cpu_exception_entry_priority

// ===== hw/exc_entry_pkg.sv
// constants and types of the exception entry unit
package exc_entry_pkg;
    localparam logic [4:0] MODE_USER = 5'h10;
    localparam logic [4:0] MODE_FIQ = 5'h11;
    localparam logic [4:0] MODE_IRQ = 5'h12;
    localparam logic [4:0] MODE_SVC = 5'h13;
    localparam logic [4:0] MODE_ABT = 5'h17;
    localparam logic [4:0] MODE_UND = 5'h1b;
    localparam logic [4:0] MODE_SYS = 5'h1f;
    localparam int MODE_LSB = 0;
    localparam int BIT_T = 5;
    localparam int BIT_F = 6;
    localparam int BIT_I = 7;
    localparam logic [31:0] VEC_RESET = 32'h00000000;
    localparam logic [31:0] VEC_UND = 32'h00000004;
    localparam logic [31:0] VEC_TRAP = 32'h00000008;
    localparam logic [31:0] VEC_PABT = 32'h0000000c;
    localparam logic [31:0] VEC_DABT = 32'h00000010;
    localparam logic [31:0] VEC_RSVD = 32'h00000014;
    localparam logic [31:0] VEC_IRQ = 32'h00000018;
    localparam logic [31:0] VEC_FIQ = 32'h0000001c;
    localparam logic [31:0] RESET_PC = 32'h00000000;
    localparam logic [31:0] STATUS_RESET = 32'h000000d3;
    localparam logic [31:0] RET_OFF_2 = 32'h00000002;
    localparam logic [31:0] RET_OFF_4 = 32'h00000004;
    localparam logic [31:0] RET_OFF_8 = 32'h00000008;
    localparam logic [1:0] XFER_SINGLE = 2'h0;
    localparam logic [1:0] XFER_SWAP = 2'h1;
    localparam logic [1:0] XFER_MULTI = 2'h2;
    localparam int NUM_BANKS = 5;
    localparam logic [2:0] BANK_SVC = 3'h0;
    localparam logic [2:0] BANK_ABT = 3'h1;
    localparam logic [2:0] BANK_UND = 3'h2;
    localparam logic [2:0] BANK_IRQ = 3'h3;
    localparam logic [2:0] BANK_FIQ = 3'h4;
    localparam logic [2:0] BANK_NONE = 3'h5;
    typedef enum logic [2:0] {
        EXC_NONE, EXC_RESET, EXC_UND, EXC_TRAP, EXC_PABT, EXC_DABT, EXC_IRQ, EXC_FIQ
    } exc_type;
endpackage : exc_entry_pkg

// ===== testbench/irq_abort_source.sv
// interrupt sources and memory abort response facing the exception unit
`timescale 1ns/1ps
module irq_abort_source (
    input wire logic i_clk_sys,
    input wire logic i_fiq_on,
    input wire logic i_irq_on,
    input wire logic i_slow,
    input wire logic i_abort_on,
    input wire logic i_fetch_done,
    input wire logic i_data_access,
    output logic o_fiq_req,
    output logic o_irq_req,
    output logic o_bus_abort
);
    logic [3:0] fiq_dly = 4'h0;
    logic [3:0] irq_dly = 4'h0;
    logic idle_pat = 1'b0;
    always_ff @(posedge i_clk_sys) begin
        fiq_dly <= {fiq_dly[2:0], i_fiq_on};
        irq_dly <= {irq_dly[2:0], i_irq_on};
        idle_pat <= ~idle_pat;
    end
    // slow sources answer four cycles late
    assign o_fiq_req = i_slow ? fiq_dly[3] : i_fiq_on;
    assign o_irq_req = i_slow ? irq_dly[3] : i_irq_on;
    // abort response only means something beside a strobe; otherwise it toggles
    assign o_bus_abort = (i_fetch_done | i_data_access) ? i_abort_on : idle_pat;
endmodule : irq_abort_source

// ===== testbench/tb_top.sv
// self-checking bench of the exception entry unit
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end
module tb_top
    import exc_entry_pkg::*;
;
    logic i_clk_sys, i_rst, i_fiq_on, i_irq_on, i_slow, i_abort_on, i_fetch_done;
    logic i_data_access, i_pipe_flush, i_boundary, i_head_undefined, i_head_trap;
    logic i_status_write, i_status_restore, fiq_req, irq_req, bus_abort;
    logic [1:0] i_xfer_kind;
    logic [31:0] i_pc, i_status_wdata, o_current_status_word, o_saved_status_word;
    logic [31:0] o_pc_target, o_link_data;
    logic o_pc_load, o_link_write, o_reg_load_suppress, o_swap_suppress;
    logic [2:0] o_link_bank;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;

    irq_abort_source src_model (.i_clk_sys(i_clk_sys), .i_fiq_on(i_fiq_on), .i_irq_on(i_irq_on),
        .i_slow(i_slow), .i_abort_on(i_abort_on), .i_fetch_done(i_fetch_done),
        .i_data_access(i_data_access), .o_fiq_req(fiq_req), .o_irq_req(irq_req),
        .o_bus_abort(bus_abort));

    cpu_exception_entry_priority dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_fiq_req(fiq_req), .i_irq_req(irq_req), .i_fetch_done(i_fetch_done),
        .i_bus_abort(bus_abort), .i_pipe_flush(i_pipe_flush), .i_data_access(i_data_access),
        .i_xfer_kind(i_xfer_kind), .i_boundary(i_boundary), .i_head_undefined(i_head_undefined),
        .i_head_trap(i_head_trap), .i_pc(i_pc), .i_status_write(i_status_write),
        .i_status_wdata(i_status_wdata), .i_status_restore(i_status_restore),
        .o_current_status_word(o_current_status_word), .o_saved_status_word(o_saved_status_word),
        .o_pc_load(o_pc_load), .o_pc_target(o_pc_target), .o_link_write(o_link_write),
        .o_link_bank(o_link_bank), .o_link_data(o_link_data),
        .o_reg_load_suppress(o_reg_load_suppress), .o_swap_suppress(o_swap_suppress));

    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task wait_n(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : wait_n

    // ends every one-cycle strobe
    task settle;
        @(posedge i_clk_sys);
        {i_boundary, i_head_undefined, i_head_trap, i_status_write} <= 4'h0;
        {i_status_restore, i_fetch_done, i_data_access, i_pipe_flush, i_abort_on} <= 5'h00;
        #1;
    endtask : settle

    task bnd(input logic [31:0] pc, input logic und, input logic trap);
        @(posedge i_clk_sys);
        i_boundary <= 1'b1;
        i_pc <= pc;
        i_head_undefined <= und;
        i_head_trap <= trap;
        settle();
    endtask : bnd

    task wr(input logic [31:0] d);
        @(posedge i_clk_sys);
        i_status_write <= 1'b1;
        i_status_wdata <= d;
        settle();
    endtask : wr

    task mem(input logic f, input logic d, input logic [1:0] k, input logic ab, input logic fl);
        @(posedge i_clk_sys);
        i_fetch_done <= f;
        i_data_access <= d;
        i_xfer_kind <= k;
        i_abort_on <= ab;
        i_pipe_flush <= fl;
        settle();
    endtask : mem

    task src(input logic f, input logic i, input logic s);
        @(posedge i_clk_sys);
        i_fiq_on <= f;
        i_irq_on <= i;
        i_slow <= s;
        wait_n(10);
    endtask : src

    task chk_entry(input logic [31:0] vec, input logic [2:0] bank, input logic [31:0] link,
                   input logic [31:0] st);
        `CHK("pc_load", 1'b1, o_pc_load)
        `CHK("pc_target", vec, o_pc_target)
        `CHK("link_write", 1'b1, o_link_write)
        `CHK("link_bank", bank, o_link_bank)
        `CHK("link_data", link, o_link_data)
        `CHK("status", st, o_current_status_word)
    endtask : chk_entry

    task t_masks;
        src(1'b1, 1'b0, 1'b0);
        bnd(32'h00000200, 1'b0, 1'b0);
        `CHK("pc_load", 1'b0, o_pc_load)
        wr(32'h00000013);
        `CHK("status", 32'h00000013, o_current_status_word)
        bnd(32'h00000204, 1'b0, 1'b0);
        chk_entry(VEC_FIQ, BANK_FIQ, 32'h00000208, 32'h000000d1);
        src(1'b0, 1'b1, 1'b1);
        wr(32'h00000011);
        bnd(32'h00000210, 1'b0, 1'b0);
        `CHK("pc_load", 1'b0, o_pc_load)
        wr(32'h00000013);
        bnd(32'h00000300, 1'b0, 1'b0);
        chk_entry(VEC_IRQ, BANK_IRQ, 32'h00000304, 32'h000000d2);
        src(1'b0, 1'b0, 1'b0);
    endtask : t_masks

    task t_aborts;
        logic [31:0] pc;
        for (int k = 0; k < 3; k++) begin
            pc = 32'h00000400 + 32'(k * 16);
            wr(32'h00000013);
            src(1'b1, 1'b0, k[0]);
            mem(1'b0, 1'b1, k[1:0], 1'b1, 1'b0);
            `CHK("suppress", 1'b1, o_reg_load_suppress)
            `CHK("swap_suppress", k == 1, o_swap_suppress)
            bnd(pc, 1'b0, 1'b0);
            chk_entry(VEC_DABT, BANK_ABT, pc + RET_OFF_8, 32'h000000d7);
            `CHK("suppress", 1'b0, o_reg_load_suppress)
            wait_n(1);
            chk_entry(VEC_FIQ, BANK_FIQ, VEC_DABT + RET_OFF_4, 32'h000000d1);
            `CHK("saved", 32'h000000d7, o_saved_status_word)
            src(1'b0, 1'b0, 1'b0);
        end
    endtask : t_aborts

    task t_prefetch;
        mem(1'b1, 1'b0, XFER_SINGLE, 1'b1, 1'b0);
        mem(1'b0, 1'b0, XFER_SINGLE, 1'b0, 1'b1);
        mem(1'b1, 1'b0, XFER_SINGLE, 1'b0, 1'b0);
        mem(1'b0, 1'b0, XFER_SINGLE, 1'b0, 1'b0);
        bnd(32'h00000500, 1'b0, 1'b0);
        `CHK("pc_load", 1'b0, o_pc_load)
        mem(1'b1, 1'b0, XFER_SINGLE, 1'b1, 1'b0);
        mem(1'b1, 1'b0, XFER_SINGLE, 1'b0, 1'b0);
        mem(1'b0, 1'b0, XFER_SINGLE, 1'b0, 1'b0);
        bnd(32'h00000510, 1'b1, 1'b0);
        chk_entry(VEC_PABT, BANK_ABT, 32'h00000514, 32'h000000d7);
    endtask : t_prefetch

    task t_und_trap;
        bnd(32'h00000600, 1'b1, 1'b0);
        chk_entry(VEC_UND, BANK_UND, 32'h00000604, 32'h000000db);
        @(posedge i_clk_sys);
        i_status_restore <= 1'b1;
        settle();
        `CHK("status", 32'h000000d7, o_current_status_word)
        wr(32'h00000033);
        bnd(32'h00000700, 1'b0, 1'b1);
        chk_entry(VEC_TRAP, BANK_SVC, 32'h00000702, 32'h000000d3);
        `CHK("saved", 32'h00000033, o_saved_status_word)
    endtask : t_und_trap

    task t_user;
        wr(32'h00000010);
        wr(32'h000000d0);
        `CHK("status", 32'h00000010, o_current_status_word)
        src(1'b1, 1'b1, 1'b0);
        bnd(32'h00000800, 1'b0, 1'b0);
        chk_entry(VEC_FIQ, BANK_FIQ, 32'h00000804, 32'h000000d1);
        bnd(32'h00000810, 1'b0, 1'b0);
        `CHK("pc_load", 1'b0, o_pc_load)
        src(1'b0, 1'b0, 1'b0);
    endtask : t_user

    initial begin
        {i_fiq_on, i_irq_on, i_slow, i_abort_on, i_fetch_done, i_data_access} = 6'h00;
        {i_pipe_flush, i_boundary, i_head_undefined, i_head_trap} = 4'h0;
        {i_status_write, i_status_restore} = 2'h0;
        i_xfer_kind = XFER_SINGLE;
        i_status_wdata = 32'h00000000;
        i_pc = 32'h00000100;
        i_rst = 1'b1;
        wait_n(11);
        `CHK("status", STATUS_RESET, o_current_status_word)
        @(posedge i_clk_sys);
        i_rst <= 1'b0;
        wait_n(1);
        chk_entry(VEC_RESET, BANK_SVC, 32'h00000100, 32'h000000d3);
        t_masks();
        t_aborts();
        t_prefetch();
        t_und_trap();
        t_user();
        tally_and_finish();
    end
endmodule : tb_top
